/* verilog/sdm_pkg.sv */
/*
  Shared constants and types for the mode register block of a two bank
  synchronous DRAM: opcode field layout, field codes, reset values, the
  register map seen over Wishbone and the packed command bundle.
  Assumes nothing of its surroundings; imported by every design file.
*/
package sdm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 12;
  localparam int DQ_W = 16;
  localparam int COL_W = 8;
  localparam int MEM_AW = COL_W + 1;
  localparam int MEM_DEPTH = 1 << MEM_AW;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode field positions on the address inputs
  localparam int BL_LSB = 0;
  localparam int BT_POS = 3;
  localparam int LT_LSB = 4;
  localparam int WM_LSB = 9;
  localparam int BANK_POS = 11;

  // Field codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] LT_2 = 3'h2;
  localparam logic [2:0] LT_3 = 3'h3;
  localparam logic [2:0] WM_BURST = 3'h0;
  localparam logic [2:0] WM_SINGLE = 3'h1;

  // Burst index masks (length minus one)
  localparam logic [7:0] LEN1_M1 = 8'h00;
  localparam logic [7:0] LEN2_M1 = 8'h01;
  localparam logic [7:0] LEN4_M1 = 8'h03;
  localparam logic [7:0] LEN8_M1 = 8'h07;
  localparam logic [7:0] PAGE_M1 = 8'hff;

  // Mode after reset: latency 2, length 1, sequential, burst write
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h020;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [WB_AW-1:0] REG_MODE = 8'h00;
  localparam logic [WB_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [WB_AW-1:0] REG_CTRL = 8'h08;
  localparam logic [WB_AW-1:0] REG_BURST = 8'h0c;

  localparam int ST_ACTIVE = 0;
  localparam int ST_RESV = 1;
  localparam int ST_WRITING = 2;
  localparam int ST_LAT3 = 3;
  localparam int CTRL_STRICT = 0;
  localparam logic CTRL_STRICT_RST = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
  } sdm_cmd_s;

  typedef struct packed {
    logic [7:0] len_m1;
    logic page;
    logic interleave;
    logic lat3;
    logic single_wr;
    logic resv;
  } sdm_mode_s;

  typedef enum logic [1:0] {
    SDM_IDLE,
    SDM_READ,
    SDM_WRITE
  } sdm_state_e;

endpackage

/* verilog/sdm_mem.sv */
/*
  Storage array for both banks: one word per bank and column, written
  on the clock edge, read data out of a register one cycle later.
  Assumes one access per cycle; no reset, contents are undefined at start.
*/
`timescale 1ns/1ps
`default_nettype none

module sdm_mem
  import sdm_pkg::*;
(
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [MEM_AW-1:0] addr_i,
  input wire logic [DQ_W-1:0] wdata_i,
  output logic [DQ_W-1:0] rdata_o
);

  logic [DQ_W-1:0] mem_q [0:MEM_DEPTH-1];
  logic [DQ_W-1:0] rdata_ff;

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  // Read before write at a shared address
  always_ff @(posedge clk_i) begin
    rdata_ff <= mem_q[addr_i];
  end

  assign rdata_o = rdata_ff;

endmodule

`default_nettype wire

/* verilog/sdm_mode_ctl.sv */
/*
  Mode register and burst engine of a two bank synchronous DRAM.
  Captures the mode set command from the command and address inputs,
  decodes read latency, burst length, burst order and write mode, and
  runs read and write bursts against the storage array.
  Assumes the command inputs and the data inputs are driven by logic on
  clk_i, and a classic Wishbone master on the same clock.
*/
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module sdm_mode_ctl
  import sdm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sdm_cmd_s cmd_i,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_n_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WB_DW-1:0] wb_dat_i,
  output logic [WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic sdm_mode_s decode_mode(input logic [ADDR_W-1:0] m);
    sdm_mode_s d;
    logic [2:0] bl;
    logic [2:0] lt;
    logic [2:0] wm;
    d = '0;
    bl = m[BL_LSB +: 3];
    lt = m[LT_LSB +: 3];
    wm = m[WM_LSB +: 3];
    d.interleave = m[BT_POS];
    d.lat3 = (lt == LT_3);
    d.single_wr = (wm == WM_SINGLE);
    case (bl)
      BL_1: d.len_m1 = LEN1_M1;
      BL_2: d.len_m1 = LEN2_M1;
      BL_4: d.len_m1 = LEN4_M1;
      BL_8: d.len_m1 = LEN8_M1;
      BL_PAGE: begin
        d.len_m1 = m[BT_POS] ? LEN1_M1 : PAGE_M1;
        d.page = ~m[BT_POS];
      end
      default: d.len_m1 = LEN1_M1;
    endcase
    // Reserved codes fall back to latency 2 and length 1
    d.resv = ((lt != LT_2) && (lt != LT_3))
      || (bl[2] && (bl != BL_PAGE))
      || ((bl == BL_PAGE) && m[BT_POS])
      || ((wm != WM_BURST) && (wm != WM_SINGLE));
    return d;
  endfunction

  // Wrap the running index inside the burst-aligned block
  function automatic logic [COL_W-1:0] burst_col(
    input logic [COL_W-1:0] start,
    input logic [COL_W-1:0] idx,
    input logic [COL_W-1:0] mask,
    input logic ilv
  );
    logic [COL_W-1:0] low;
    low = ilv ? (start ^ idx) : COL_W'(start + idx);
    return (start & ~mask) | (low & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  logic strobe_low;
  logic is_mode_set;
  logic is_read;
  logic is_write;
  logic is_other;
  sdm_mode_s new_mode;

  assign strobe_low = ~cmd_i.cs_n;
  assign is_mode_set = strobe_low & ~cmd_i.ras_n & ~cmd_i.cas_n
    & ~cmd_i.we_n;
  assign is_read = strobe_low & cmd_i.ras_n & ~cmd_i.cas_n & cmd_i.we_n;
  assign is_write = strobe_low & cmd_i.ras_n & ~cmd_i.cas_n & ~cmd_i.we_n;
  // Any command other than a no-operation ends a running burst
  assign is_other = strobe_low & ~is_read & ~is_write
    & ~(cmd_i.ras_n & cmd_i.cas_n & cmd_i.we_n);
  assign new_mode = decode_mode(cmd_i.addr);

  ////////////////////////////////////////////////////////////////////////////
  // Mode register and control bits

  logic [ADDR_W-1:0] mode_ff;
  logic strict_ff;
  logic resv_ff;
  sdm_mode_s cur_mode;
  logic wb_req;
  logic wb_wr_now;
  logic wb_hit_status;
  logic wb_hit_ctrl;

  assign cur_mode = decode_mode(mode_ff);
  assign wb_req = wb_cyc_i & wb_stb_i;
  // A write commits on the edge at which the master sees ack
  assign wb_wr_now = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wb_hit_status = (wb_adr_i == REG_STATUS);
  assign wb_hit_ctrl = (wb_adr_i == REG_CTRL);

  // Banks idle at mode set is the controller's duty; no check here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= MODE_RST;
    end else if (is_mode_set && !(strict_ff && new_mode.resv)) begin
      mode_ff <= cmd_i.addr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strict_ff <= CTRL_STRICT_RST;
    end else if (wb_wr_now && wb_hit_ctrl) begin
      strict_ff <= wb_dat_i[CTRL_STRICT];
    end
  end

  // Sticky reserved-code flag; a new event beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resv_ff <= 1'b0;
    end else if (is_mode_set && new_mode.resv) begin
      resv_ff <= 1'b1;
    end else if (wb_wr_now && wb_hit_status && wb_dat_i[ST_RESV]) begin
      resv_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst engine

  sdm_state_e state_ff;
  sdm_state_e nxt_state;
  logic bank_ff;
  logic nxt_bank;
  logic [COL_W-1:0] start_ff;
  logic [COL_W-1:0] nxt_start;
  logic [COL_W-1:0] idx_ff;
  logic [COL_W-1:0] nxt_idx;
  logic [COL_W-1:0] len_ff;
  logic [COL_W-1:0] nxt_len;
  logic page_ff;
  logic nxt_page;
  logic [COL_W-1:0] cmd_len;
  logic cmd_page;

  // Single write mode shortens writes only, reads keep the length
  assign cmd_len = (is_write && cur_mode.single_wr) ? LEN1_M1
    : cur_mode.len_m1;
  assign cmd_page = cur_mode.page & ~(is_write & cur_mode.single_wr);

  always_comb begin
    nxt_state = state_ff;
    nxt_bank = bank_ff;
    nxt_start = start_ff;
    nxt_idx = idx_ff;
    nxt_len = len_ff;
    nxt_page = page_ff;
    if (is_read || is_write) begin
      nxt_bank = cmd_i.addr[BANK_POS];
      nxt_start = cmd_i.addr[COL_W-1:0];
      nxt_idx = 8'h01;
      nxt_len = cmd_len;
      nxt_page = cmd_page;
      if (cmd_len == LEN1_M1) begin
        nxt_state = SDM_IDLE;
      end else if (is_read) begin
        nxt_state = SDM_READ;
      end else begin
        nxt_state = SDM_WRITE;
      end
    end else if (is_other) begin
      nxt_state = SDM_IDLE;
    end else begin
      case (state_ff)
        SDM_READ, SDM_WRITE: begin
          // A full page wraps until another command stops it
          if (idx_ff == len_ff && !page_ff) begin
            nxt_state = SDM_IDLE;
          end
          nxt_idx = COL_W'(idx_ff + 8'h01);
        end
        SDM_IDLE: nxt_idx = idx_ff;
        default: nxt_state = SDM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= SDM_IDLE;
      bank_ff <= 1'b0;
      start_ff <= '0;
      idx_ff <= '0;
      len_ff <= LEN1_M1;
      page_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bank_ff <= nxt_bank;
      start_ff <= nxt_start;
      idx_ff <= nxt_idx;
      len_ff <= nxt_len;
      page_ff <= nxt_page;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage access

  logic [MEM_AW-1:0] mem_addr;
  logic mem_we;
  logic [DQ_W-1:0] mem_rdata;
  logic rd_issue;

  // The command cycle uses the pins; later items use the generator
  assign mem_addr = (is_read || is_write)
    ? {cmd_i.addr[BANK_POS], cmd_i.addr[COL_W-1:0]}
    : {bank_ff, burst_col(start_ff, idx_ff, len_ff,
       cur_mode.interleave)};
  // Write data is taken in the command cycle itself, latency zero
  assign mem_we = is_write
    | ((state_ff == SDM_WRITE) & ~is_read & ~is_other);
  assign rd_issue = is_read
    | ((state_ff == SDM_READ) & ~is_write & ~is_other);

  sdm_mem u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(dq_i),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read latency pipeline

  logic rv0_ff;
  logic rv1_ff;
  logic [DQ_W-1:0] rd1_ff;
  logic [DQ_W-1:0] dq_ff;
  logic oe_n_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rv0_ff <= 1'b0;
      rv1_ff <= 1'b0;
      rd1_ff <= '0;
    end else begin
      rv0_ff <= rd_issue;
      rv1_ff <= rv0_ff;
      rd1_ff <= mem_rdata;
    end
  end

  // Latency 2 drives one stage after the array, latency 3 two stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq_ff <= '0;
      oe_n_ff <= 1'b1;
    end else if (cur_mode.lat3) begin
      dq_ff <= rd1_ff;
      oe_n_ff <= ~rv1_ff;
    end else begin
      dq_ff <= mem_rdata;
      oe_n_ff <= ~rv0_ff;
    end
  end

  assign dq_o = dq_ff;
  assign dq_oe_n_o = oe_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  logic ack_ff;
  logic [WB_DW-1:0] dat_ff;
  logic [WB_DW-1:0] nxt_dat;

  always_comb begin
    nxt_dat = '0;
    case (wb_adr_i)
      REG_MODE: nxt_dat[ADDR_W-1:0] = mode_ff;
      REG_STATUS: begin
        nxt_dat[ST_ACTIVE] = (state_ff != SDM_IDLE);
        nxt_dat[ST_RESV] = resv_ff;
        nxt_dat[ST_WRITING] = (state_ff == SDM_WRITE);
        nxt_dat[ST_LAT3] = cur_mode.lat3;
      end
      REG_CTRL: nxt_dat[CTRL_STRICT] = strict_ff;
      REG_BURST: nxt_dat[2*COL_W:0] = {bank_ff, start_ff, idx_ff};
      default: nxt_dat = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
    end else begin
      ack_ff <= wb_req & ~ack_ff;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

endmodule

`default_nettype wire

/* tb/sdm_ctl_model.sv */
/*
  Controller stand-in that drives the command, address and data pins.
  Assumes the testbench calls its tasks from one process on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module sdm_ctl_model
  import sdm_pkg::*;
(
  input wire logic clk_i,
  output var sdm_cmd_s cmd_o,
  output logic [DQ_W-1:0] dq_o
);
  initial begin
    cmd_o = {4'hf, 12'h5a5};
    dq_o = 16'h5a5a;
  end

  // Address goes out once, with the command
  task automatic put(input logic [3:0] s, input logic [11:0] a,
      input logic [DQ_W-1:0] d);
    @(posedge clk_i);
    cmd_o <= {s, a};
    dq_o <= d;
  endtask

  // Deselected cycles toggle the lines so stale values never look valid
  task automatic dat(input logic [DQ_W-1:0] d);
    @(posedge clk_i);
    cmd_o <= {4'hf, ~cmd_o.addr};
    dq_o <= d;
  endtask

  task automatic idle(input int n);
    repeat (n) dat(~dq_o);
  endtask

  // Caller picks latency and only listed write modes; banks are idle
  task automatic mode_set(input logic [11:0] op);
    put(4'h0, op, ~dq_o);
    idle(2);
  endtask
endmodule

`default_nettype wire

/* tb/sdm_mode_ctl_properties.sv */
/*
  Checker on the ports of sdm_mode_ctl, bound at the foot of this file.
  Assumes bus writes commit at ack; the strict bit is shadowed from them,
  so a refused mode set leaves the shadow mode unchanged too.
*/
`timescale 1ns/1ps
`default_nettype none

module sdm_mode_ctl_properties
  import sdm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sdm_cmd_s cmd_i,
  input wire logic [DQ_W-1:0] dq_i,
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic dq_oe_n_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WB_DW-1:0] wb_dat_i,
  input wire logic [WB_DW-1:0] wb_dat_o,
  input wire logic wb_ack_o
);
  logic [ADDR_W-1:0] mode_ff;
  logic [8:0] run_ff;
  logic rd, ms, lat3, page;
  logic strict_ff, ctl_wr, ms_resv;
  int exp_len;

  assign rd = !cmd_i.cs_n && cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n;
  assign ms = !cmd_i.cs_n && !cmd_i.ras_n && !cmd_i.cas_n && !cmd_i.we_n;
  assign lat3 = mode_ff[6:4] == LT_3;
  assign page = mode_ff[2:0] == BL_PAGE && !mode_ff[BT_POS];
  // Reserved length codes run as a single item
  assign exp_len = mode_ff[2] ? 1 : 1 << mode_ff[1:0];

  // Strict mode refuses reserved opcodes, so a mode set may not load
  assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
    && wb_sel_i[0] && wb_adr_i == REG_CTRL;
  assign ms_resv = !(cmd_i.addr[6:4] inside {LT_2, LT_3})
    || (cmd_i.addr[2] && cmd_i.addr[3:0] != 4'h7)
    || !(cmd_i.addr[11:9] inside {WM_BURST, WM_SINGLE});

  always_ff @(posedge clk_i) begin
    if (rst_i) strict_ff <= CTRL_STRICT_RST;
    else if (ctl_wr) strict_ff <= wb_dat_i[CTRL_STRICT];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) mode_ff <= MODE_RST;
    else if (ms && !(strict_ff && ms_resv)) mode_ff <= cmd_i.addr;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || dq_oe_n_o) run_ff <= '0;
    else run_ff <= run_ff + 9'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_turn_on;
    dq_oe_n_o ##1 !dq_oe_n_o;
  endsequence

  a_lat_two: assert property (rd && !lat3 && dq_oe_n_o |=> s_turn_on)
    else $error("read data not two cycles after read");
  a_lat_three: assert property (rd && lat3 && dq_oe_n_o
      |=> dq_oe_n_o ##1 s_turn_on)
    else $error("read data not three cycles after read");
  a_burst_span: assert property ($rose(dq_oe_n_o) && !page
      |-> run_ff == exp_len)
    else $error("read burst length wrong");
  a_page_runs: assert property ($fell(dq_oe_n_o) && page
      |-> !dq_oe_n_o [*8])
    else $error("full page read ended early");
  a_mode_kept: assert property (wb_ack_o && !wb_we_i
      && wb_adr_i == REG_MODE |-> wb_dat_o[11:0] == mode_ff)
    else $error("mode register differs from last mode set");
  a_lat_flag: assert property (wb_ack_o && !wb_we_i
      && wb_adr_i == REG_STATUS |-> wb_dat_o[ST_LAT3] == lat3)
    else $error("latency flag wrong");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule

bind sdm_mode_ctl sdm_mode_ctl_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .dq_i(dq_i), .dq_o(dq_o),
  .dq_oe_n_o(dq_oe_n_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);

`default_nettype wire

/* tb/tb.sv */
/*
  Self-checking bench: random mode sets, write bursts, read-back bursts.
  Assumes the controller model in sdm_ctl_model and a Wishbone master here.
*/
`timescale 1ns/1ps
`default_nettype none

module tb
  import sdm_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0, rdat, q;
  logic [15:0] dq_o, dqi;
  logic dq_oe_n_o;
  sdm_cmd_s cmd;
  logic [15:0] exp_mem [512];
  int n_fail = 0, comparisons = 0;

  initial forever #5 clk_i = ~clk_i;

  sdm_ctl_model ctl (.clk_i(clk_i), .cmd_o(cmd), .dq_o(dqi));
  sdm_mode_ctl dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .dq_i(dqi),
    .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    int t;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (ack !== 1'b1) begin
      n_fail++;
      results();
    end
    r = rdat;
    cyc <= 0;
    stb <= 0;
  endtask

  // Burst location: block aligned to the length, order within the block
  function automatic logic [8:0] loc(input logic bk, input logic [7:0] c,
      input logic [7:0] k, input logic [7:0] m, input logic ilv);
    logic [7:0] o;
    o = ilv ? c ^ k : c + k;
    return {bk, (c & ~m) | (o & m)};
  endfunction

  // Opcodes outside the latency, length and write mode tables
  function automatic logic rsv(input logic [11:0] o);
    return !(o[6:4] inside {LT_2, LT_3}) || (o[2] && o[3:0] != 4'h7)
      || !(o[11:9] inside {WM_BURST, WM_SINGLE});
  endfunction

  initial begin
    logic [11:0] op;
    logic [7:0] col, m;
    logic [15:0] d;
    logic bk, resv_exp;
    int n, lat, len;
    void'($urandom(19));
    resv_exp = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, REG_MODE, 0, q);
    chk("mode", q, {20'h0, MODE_RST});
    wb(1, REG_MODE, '1, q);
    wb(0, 8'h40, 0, q);
    chk("unmapped", q, 0);
    wb(0, REG_MODE, 0, q);
    chk("mode", q, {20'h0, MODE_RST});
    // Fill both banks so no read compares an unknown with an unknown
    ctl.mode_set(12'h027);
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < 256; k++) begin
        d = 16'($urandom);
        exp_mem[{1'(b), 8'(k)}] = d;
        if (k == 0) ctl.put(4'h4, {1'(b), 11'h0}, d);
        else ctl.dat(d);
      end
      ctl.put(4'h6, 12'h0, ~d);
    end
    for (int i = 0; i < 40; i++) begin
      op = {2'b00, 1'($urandom), 2'b00, 3'($urandom), 1'($urandom),
        3'($urandom)};
      if (i < 2) op[3:0] = 4'h7;
      if (i == 2) op[3:0] = 4'hb;
      ctl.mode_set(op);
      wb(0, REG_STATUS, 0, q);
      chk("lat3", q[3], op[6:4] == LT_3);
      resv_exp = resv_exp | rsv(op);
      chk("status", q[2:0], {1'b0, resv_exp, 1'b0});
      if (resv_exp) begin
        wb(1, REG_STATUS, 32'h2, q);
        resv_exp = 0;
      end
      wb(0, REG_MODE, 0, q);
      chk("mode", q, {20'h0, op});
      len = (op[2:0] == BL_PAGE && !op[3]) ? 256 : op[2] ? 1 : 1 << op[1:0];
      n = len > 8 ? 8 : len;
      m = 8'(len - 1);
      lat = op[6:4] == LT_3 ? 3 : 2;
      bk = 1'($urandom);
      col = 8'($urandom);
      for (int k = 0; k < n; k++) begin
        d = 16'($urandom);
        if (k == 0) ctl.put(4'h4, {bk, 3'h0, col}, d);
        else ctl.dat(d);
        if (k == 0 || !op[WM_LSB])
          exp_mem[loc(bk, col, 8'(k), m, op[3])] = d;
      end
      if (len > 8) ctl.put(4'h6, 12'h0, exp_mem[loc(bk, col, 8'h8, m, 1'b0)]);
      ctl.idle(2);
      ctl.put(4'h5, {bk, 3'h0, col}, 16'($urandom));
      // Deselect at once: a held read would restart the burst each cycle
      ctl.idle(lat);
      #1;
      chk("oe", dq_oe_n_o, 0);
      for (int k = 0; k < n; k++) begin
        if (k > 0) begin
          @(posedge clk_i);
          #1;
        end
        chk("dq", dq_o, exp_mem[loc(bk, col, 8'(k), m, op[3])]);
      end
      @(posedge clk_i);
      #1;
      chk("oe end", dq_oe_n_o, len > 8 ? 0 : 1);
      if (len > 8) begin
        wb(0, REG_STATUS, 0, q);
        chk("busy", q[3:0], {lat == 3, 1'b0, resv_exp, 1'b1});
        wb(0, REG_BURST, 0, q);
        chk("start", q[16:8], {bk, col});
      end
      if (len > 8) ctl.put(4'h6, 12'h0, ~dqi);
      ctl.idle(2);
    end
    // Strict mode: a reserved opcode is refused and only flagged
    wb(1, REG_CTRL, 32'h1, q);
    wb(0, REG_CTRL, 0, q);
    chk("strict", q, 32'h1);
    wb(0, REG_MODE, 0, q);
    op = q[11:0];
    ctl.mode_set(12'h014);
    wb(0, REG_MODE, 0, q);
    chk("refused", q, {20'h0, op});
    wb(0, REG_STATUS, 0, q);
    chk("resv seen", q[1], 1'b1);
    ctl.mode_set(12'h033);
    wb(0, REG_MODE, 0, q);
    chk("strict load", q, 32'h033);
    wb(1, REG_CTRL, 0, q);
    results();
  end
endmodule

`default_nettype wire
